// >>> rtl/xfer_wait_consts.svh
// Constants for the transfer, test and wait instruction decoder
`ifndef XFER_WAIT_CONSTS_SVH
`define XFER_WAIT_CONSTS_SVH
`define OP_PREFIX_Y      8'h18
`define OP_TEST_MODE     8'h00
`define OP_A_TO_FLAGS    8'h06
`define OP_FLAGS_TO_A    8'h07
`define OP_MEM_CHK_EXT   8'h7D
`define OP_MEM_CHK_IDX   8'h6D
`define OP_ACC_A_CHK     8'h4D
`define OP_ACC_B_CHK     8'h5D
`define OP_SP_TO_IDX     8'h30
`define OP_IDX_TO_SP     8'h35
`define OP_WAIT_INT      8'h3E
`define CYC_INH_SHORT    5'h02
`define CYC_XFER_X       5'h03
`define CYC_MEM_CHK      5'h06
`define CYC_WAIT_STACK   5'h0C
`define CYC_WAIT_VECTOR  5'h02
`define FLAG_X_BIT       6
`define FLAG_N_BIT       3
`define FLAG_Z_BIT       2
`define FLAG_V_BIT       1
`define FLAG_C_BIT       0
`define FLAGS_RESET      8'hD0
`define SP_RESET         16'h0000
`endif

// >>> rtl/xfer_wait_pkg.sv
// Types for the transfer, test and wait instruction decoder
package xfer_wait_pkg;
   typedef enum logic [5:0] {
      ST_FETCH  = 6'b000001,
      ST_EXEC   = 6'b000010,
      ST_STACK  = 6'b000100,
      ST_IDLE   = 6'b001000,
      ST_VECTOR = 6'b010000,
      ST_TEST   = 6'b100000
   } cpu_state_t;
endpackage

// >>> rtl/xfer_wait_decode.sv
// Decode and timing of transfer, test and wait instructions
//
// Contract
// RULE1: Opcode 06, 2 cycles: flags from A; X mask may clear, never set.
// RULE2: Opcode 07, 2 cycles: flags copied to A, flags unchanged.
// RULE3: Opcode 00 in test mode increments the address bus until reset.
// RULE4: Memory check: N,Z from operand, V,C cleared; 6 cycles, 7 with prefix.
// RULE5: Opcodes 4D/5D, 2 cycles: N,Z from accumulator, V,C cleared.
// RULE6: Stack pointer plus one into index; 3 cycles for X, 4 for Y.
// RULE7: Index minus one into stack pointer; 3 cycles for X, 4 for Y.
// RULE8: Wait: 12 stacking cycles, n idle cycles, 2 vector cycles.
// RULE9: Direct address is operand byte with a zero high byte.
// RULE10: Indexed address is index plus unsigned operand byte.
// RULE11: Relative target is next address plus sign-extended offset.
// RULE12: Prefix 18 selects the Y form and adds one cycle.
`timescale 1ns/1ps
`include "xfer_wait_consts.svh"
module xfer_wait_decode
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        op_valid,
   input  wire logic [7:0]  op_byte,
   input  wire logic [7:0]  operand_lo,
   input  wire logic [7:0]  operand_hi,
   input  wire logic [7:0]  mem_data,
   input  wire logic [15:0] next_pc,
   input  wire logic        test_mode,
   input  wire logic        int_pending,
   input  wire logic [7:0]  acc_a,
   input  wire logic [7:0]  acc_b,
   output logic             busy,
   output logic             done,
   output logic [7:0]       flags,
   output logic [15:0]      stack_ptr,
   output logic [15:0]      index_reg_one,
   output logic [15:0]      index_reg_two,
   output logic [7:0]       acc_a_out,
   output logic             acc_a_load,
   output logic [15:0]      addr_bus,
   output logic [15:0]      direct_addr,
   output logic [15:0]      indexed_addr,
   output logic [15:0]      relative_addr,
   output logic             waiting
);
   localparam logic [4:0] ONE = 5'h01;

   xfer_wait_pkg::cpu_state_t state_reg, state_next;
   logic        prefix_reg;
   logic [7:0]  op_reg;
   logic [7:0]  mem_reg;
   logic [4:0]  cnt_reg;

   // Cycle counts per opcode; prefix adds one
   wire  [4:0] base_cycles =
      (op_byte == `OP_MEM_CHK_EXT || op_byte == `OP_MEM_CHK_IDX) ? `CYC_MEM_CHK :
      (op_byte == `OP_SP_TO_IDX || op_byte == `OP_IDX_TO_SP) ? `CYC_XFER_X :
      `CYC_INH_SHORT;
   // Y forms pay their extra cycle in the separate prefix fetch
   wire  [4:0] op_cycles  = base_cycles; // RULE4 RULE6 RULE7 RULE12

   wire        is_prefix  = op_valid && op_byte == `OP_PREFIX_Y;
   wire        start      = op_valid && !is_prefix;
   wire        is_wait    = op_byte == `OP_WAIT_INT;
   wire        is_test    = op_byte == `OP_TEST_MODE && test_mode; // RULE3
   wire [15:0] sel_index  = prefix_reg ? index_reg_two : index_reg_one; // RULE12

   // Address formation for all operand forms
   wire [15:0] dir_a  = {8'h00, operand_lo}; // RULE9
   wire [15:0] idx_a  = sel_index + {8'h00, operand_lo}; // RULE10
   wire [15:0] rel_a  = next_pc + {{8{operand_lo[7]}}, operand_lo}; // RULE11
   wire [15:0] ext_a  = {operand_hi, operand_lo};
   wire [15:0] mem_a  = (op_byte == `OP_MEM_CHK_EXT) ? ext_a : idx_a;

   // Flag results
   wire [7:0] chk_val  = (op_reg == `OP_ACC_A_CHK) ? acc_a :
                         (op_reg == `OP_ACC_B_CHK) ? acc_b : mem_reg;
   wire [7:0] chk_flags = {flags[7:4], chk_val[7], chk_val == 8'h00, 2'b00}; // RULE4 RULE5
   // X mask only falls: hardware never lets software raise it
   wire [7:0] tap_flags = {acc_a[7], acc_a[`FLAG_X_BIT] & flags[`FLAG_X_BIT],
                           acc_a[5:0]}; // RULE1
   wire       exec_last = state_reg == xfer_wait_pkg::ST_EXEC && cnt_reg == ONE;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         xfer_wait_pkg::ST_FETCH:
            if (start && is_test)
               state_next = xfer_wait_pkg::ST_TEST;
            else if (start && is_wait)
               state_next = xfer_wait_pkg::ST_STACK;
            else if (start)
               state_next = xfer_wait_pkg::ST_EXEC;
         xfer_wait_pkg::ST_EXEC:
            if (cnt_reg == ONE)
               state_next = xfer_wait_pkg::ST_FETCH;
         xfer_wait_pkg::ST_STACK:
            if (cnt_reg == ONE)
               state_next = xfer_wait_pkg::ST_IDLE;
         // No time limit: only a recognised interrupt ends the wait
         xfer_wait_pkg::ST_IDLE:
            if (int_pending)
               state_next = xfer_wait_pkg::ST_VECTOR;
         xfer_wait_pkg::ST_VECTOR:
            if (cnt_reg == ONE)
               state_next = xfer_wait_pkg::ST_FETCH;
         // Only reset leaves the test loop
         xfer_wait_pkg::ST_TEST:
            state_next = xfer_wait_pkg::ST_TEST; // RULE3
         default:
            state_next = xfer_wait_pkg::ST_FETCH;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= xfer_wait_pkg::ST_FETCH;
         cnt_reg   <= 5'h00;
         op_reg    <= 8'h00;
         mem_reg   <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == xfer_wait_pkg::ST_FETCH && start)
         begin
            op_reg  <= op_byte;
            mem_reg <= mem_data;
            // Fetch cycle counts as the first cycle
            cnt_reg <= is_wait ? `CYC_WAIT_STACK - ONE : op_cycles - ONE; // RULE8
         end
         else if (state_reg == xfer_wait_pkg::ST_IDLE && int_pending)
            cnt_reg <= `CYC_WAIT_VECTOR; // RULE8
         else if (cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - ONE;
      end
   end

   // Prefix lives until the last execute cycle, or the stacking cycles, of the opcode it precedes
   // A repeated prefix only sets the flag again
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         prefix_reg <= 1'b0;
      else if (state_reg == xfer_wait_pkg::ST_FETCH && is_prefix)
         prefix_reg <= 1'b1; // RULE12
      else if (exec_last || state_reg == xfer_wait_pkg::ST_STACK)
         prefix_reg <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         flags         <= `FLAGS_RESET;
         stack_ptr     <= `SP_RESET;
         index_reg_one <= 16'h0000;
         index_reg_two <= 16'h0000;
         acc_a_out     <= 8'h00;
         acc_a_load    <= 1'b0;
      end
      else
      begin
         acc_a_load <= 1'b0;
         if (exec_last)
         begin
            case (op_reg)
               `OP_A_TO_FLAGS: flags <= tap_flags; // RULE1
               `OP_FLAGS_TO_A:
               begin
                  acc_a_out  <= flags; // RULE2
                  acc_a_load <= 1'b1;
               end
               `OP_MEM_CHK_EXT, `OP_MEM_CHK_IDX, `OP_ACC_A_CHK, `OP_ACC_B_CHK:
                  flags <= chk_flags; // RULE4 RULE5
               `OP_SP_TO_IDX:
                  if (prefix_reg)
                     index_reg_two <= stack_ptr + 16'h0001; // RULE6
                  else
                     index_reg_one <= stack_ptr + 16'h0001; // RULE6
               `OP_IDX_TO_SP:
                  stack_ptr <= sel_index - 16'h0001; // RULE7
               default:
                  flags <= flags;
            endcase
         end
      end
   end

   // Address bus and status
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         addr_bus      <= 16'h0000;
         direct_addr   <= 16'h0000;
         indexed_addr  <= 16'h0000;
         relative_addr <= 16'h0000;
         busy          <= 1'b0;
         done          <= 1'b0;
         waiting       <= 1'b0;
      end
      else
      begin
         direct_addr   <= dir_a;
         indexed_addr  <= idx_a;
         relative_addr <= rel_a;
         // Operand address is latched as the opcode is taken
         if (state_next == xfer_wait_pkg::ST_TEST)
            addr_bus <= addr_bus + 16'h0001; // RULE3
         else if (state_reg == xfer_wait_pkg::ST_FETCH && start)
            addr_bus <= mem_a;
         busy    <= state_next != xfer_wait_pkg::ST_FETCH;
         done    <= state_reg != xfer_wait_pkg::ST_FETCH
                    && state_reg != xfer_wait_pkg::ST_TEST
                    && state_next == xfer_wait_pkg::ST_FETCH;
         waiting <= state_next == xfer_wait_pkg::ST_IDLE; // RULE8
      end
   end
endmodule // xfer_wait_decode

// >>> tb/xfer_wait_decode_asserts.sv
// Port checks for the transfer, test and wait decoder
`timescale 1ns/1ps
module xfer_wait_decode_asserts
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        op_valid,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        waiting,
   input wire logic        int_pending,
   input wire logic        test_mode,
   input wire logic [7:0]  op_byte,
   input wire logic [7:0]  flags,
   input wire logic [7:0]  acc_a,
   input wire logic [7:0]  operand_lo,
   input wire logic [15:0] direct_addr,
   input wire logic [15:0] addr_bus
);
   logic pfx_reg;
   // Prefixed opcodes have other counts, so plain forms exclude them
   wire  tx = op_valid && !busy && !pfx_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk or posedge reset)
      if (reset)
         pfx_reg <= 1'h0;
      else if (op_valid && !busy)
         pfx_reg <= op_byte == 8'h18;
   AST_A_TO_FLAGS: assert property (
      tx && op_byte == 8'h06 |-> ##2 done && flags == {$past(acc_a[7], 2),
      $past(acc_a[6], 2) & $past(flags[6], 2), $past(acc_a[5:0], 2)}) else $error("bad load");
   AST_FLAGS_TO_A: assert property (
      tx && op_byte == 8'h07 |-> ##2 done && flags == $past(flags, 2)) else $error("flags moved");
   AST_ACC_A_CHK: assert property (
      tx && op_byte == 8'h4D |-> ##2 done &&
      flags[3:0] == {$past(acc_a[7], 2), ~|$past(acc_a, 2), 2'h0}) else $error("bad test");
   AST_SP_TO_X: assert property (
      tx && op_byte == 8'h30 |-> ##2 !done ##1 done) else $error("bad count");
   AST_X_TO_SP: assert property (
      tx && op_byte == 8'h35 |=> busy [*2] ##1 done && !busy) else $error("bad count");
   AST_WAIT: assert property (
      tx && op_byte == 8'h3E |-> ##11 !waiting ##1 waiting) else $error("bad stacking");
   AST_VEC: assert property (
      waiting && int_pending |=> !waiting && !done ##1 !done ##1 done) else $error("bad vector");
   AST_DIR: assert property (
      !$past(reset) |-> direct_addr == {8'h00, $past(operand_lo)}) else $error("bad direct");
   AST_TEST_LOOP: assert property (
      tx && op_byte == 8'h00 && test_mode |=> addr_bus == $past(addr_bus) + 16'h0001
      ##1 addr_bus == $past(addr_bus) + 16'h0001) else $error("address bus stalled");
   AST_TEST_OFF: assert property (
      tx && op_byte == 8'h00 && !test_mode |-> ##2 done) else $error("test opcode acted");
   AST_Y_XFER: assert property (
      op_valid && !busy && op_byte == 8'h18 ##1 op_valid && (op_byte == 8'h30 || op_byte == 8'h35)
      |-> ##3 done) else $error("bad prefixed count");
endmodule // xfer_wait_decode_asserts
bind xfer_wait_decode xfer_wait_decode_asserts i_chk
(
   .clk         (clk),
   .reset       (reset),
   .op_valid    (op_valid),
   .busy        (busy),
   .done        (done),
   .waiting     (waiting),
   .int_pending (int_pending),
   .test_mode   (test_mode),
   .op_byte     (op_byte),
   .flags       (flags),
   .acc_a       (acc_a),
   .operand_lo  (operand_lo),
   .direct_addr (direct_addr),
   .addr_bus    (addr_bus)
);

// >>> tb/prog_mem_model.sv
// Program memory model feeding the opcode stream
`timescale 1ns/1ps
module prog_mem_model
(
   input  wire logic [3:0] addr,
   output logic      [7:0] code
);
   logic [7:0] rom [13] = '{8'h06, 8'h07, 8'h4D, 8'h5D, 8'h7D, 8'h6D, 8'h30,
      8'h35, 8'h6D, 8'h30, 8'h35, 8'h3E, 8'h00};
   assign code = rom[addr];
endmodule // prog_mem_model

// >>> tb/cpu_transfer_test_wait_decode_tb.sv
// Random and corner tests of the transfer, test and wait decoder
`timescale 1ns/1ps
module cpu_transfer_test_wait_decode_tb;
   logic        clk = 1'h0;
   logic        reset, op_valid, test_mode, int_pending, busy, done, acc_a_load, waiting, y;
   logic [7:0]  op_byte, operand_lo, operand_hi, mem_data, acc_a, acc_b, flags, acc_a_out, code, ef;
   logic [15:0] next_pc, stack_ptr, index_reg_one, index_reg_two, addr_bus, esp, ex, ey, a;
   logic [15:0] direct_addr, indexed_addr, relative_addr;
   logic [3:0]  pc;
   integer      errors, n_checks, seed, i, n, c;
   xfer_wait_decode i_dut
   (
      .clk           (clk),
      .reset         (reset),
      .op_valid      (op_valid),
      .op_byte       (op_byte),
      .operand_lo    (operand_lo),
      .operand_hi    (operand_hi),
      .mem_data      (mem_data),
      .next_pc       (next_pc),
      .test_mode     (test_mode),
      .int_pending   (int_pending),
      .acc_a         (acc_a),
      .acc_b         (acc_b),
      .busy          (busy),
      .done          (done),
      .flags         (flags),
      .stack_ptr     (stack_ptr),
      .index_reg_one (index_reg_one),
      .index_reg_two (index_reg_two),
      .acc_a_out     (acc_a_out),
      .acc_a_load    (acc_a_load),
      .addr_bus      (addr_bus),
      .direct_addr   (direct_addr),
      .indexed_addr  (indexed_addr),
      .relative_addr (relative_addr),
      .waiting       (waiting)
   );
   prog_mem_model i_mem (.addr(pc), .code(code));
   always #50 clk = ~clk;
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      errors += got !== exp;
      if (got !== exp)
         $display("Error %0t: %h not %h", $time, got, exp);
   endtask
   task automatic chk_byte(input logic [7:0] got, exp);
      n_checks++;
      errors += got !== exp;
      if (got !== exp)
         $display("Error %0t: byte %h not %h", $time, got, exp);
   endtask
   task automatic chk_cyc(input integer got, exp);
      n_checks++;
      errors += got !== exp;
      if (got !== exp)
         $display("Error %0t: %0d cycles not %0d", $time, got, exp);
   endtask
   task automatic print_verdict;
      if (errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic integer ncyc(input logic [7:0] op);
      ncyc = op == 8'h3E ? 14 + n : op inside {8'h6D, 8'h7D} ? 6 : op inside {8'h30, 8'h35} ? 3 : 2;
   endfunction
   function automatic logic [15:0] mem_addr(input logic [7:0] op, input logic pfx);
      mem_addr = op == 8'h7D ? {operand_hi, operand_lo}
                             : (pfx ? ey : ex) + {8'h00, operand_lo};
   endfunction
   // Prefix sent first; a one-cycle interrupt ends the wait after n idle cycles
   task automatic step;
      {op_byte, op_valid} <= {y ? 8'h18 : code, 1'h1};
      @(posedge clk);
      {op_byte, op_valid} <= {code, y};
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
         op_valid <= 1'h0;
         int_pending <= c == 10 + n;
      end
      while (done !== 1'h1 && c < 60);
      chk_cyc(c, ncyc(code) + y);
   endtask
   initial
   begin
      {op_valid, test_mode, int_pending, op_byte, operand_lo, operand_hi} = '0;
      {mem_data, acc_a, acc_b, next_pc, pc, errors, n_checks, esp, ex, ey} = '0;
      {reset, seed, ef} = {1'h1, 32'h1F162570, 8'hD0};
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      for (i = 0; i < 39; i++)
      begin
         // Clear X, test a zero A, then try to set X again
         acc_a <= i == 0 || i == 2 ? 8'h00 : i == 13 ? 8'hFF : 8'($random(seed));
         {acc_b, mem_data, operand_lo, operand_hi} <= $random(seed);
         next_pc <= 16'($random(seed));
         // At least one idle cycle before the interrupt
         n = ($random(seed) & 7) + 1;
         pc = 4'(i % 13);
         y = pc inside {[8:10]};
         @(posedge clk);
         case (code)
            8'h06: ef = {acc_a[7], acc_a[6] & ef[6], acc_a[5:0]};
            8'h4D: ef[3:0] = {acc_a[7], acc_a == 8'h00, 2'h0};
            8'h5D: ef[3:0] = {acc_b[7], acc_b == 8'h00, 2'h0};
            8'h6D, 8'h7D: ef[3:0] = {mem_data[7], mem_data == 8'h00, 2'h0};
            8'h30: {ey, ex} = y ? {esp + 16'h1, ex} : {ey, esp + 16'h1};
            8'h35: esp = (y ? ey : ex) - 16'h1;
         endcase
         step();
         chk_byte(flags, ef);
         chk(stack_ptr, esp);
         chk(index_reg_one, ex);
         chk(index_reg_two, ey);
         chk(direct_addr, {8'h00, operand_lo});
         chk(relative_addr, next_pc + {{8{operand_lo[7]}}, operand_lo});
         if (!y && code != 8'h30) chk(indexed_addr, ex + operand_lo);
         if (code == 8'h07) chk_byte(acc_a_out, ef);
         chk_byte({7'h00, acc_a_load}, {7'h00, code == 8'h07});
         if (code inside {8'h6D, 8'h7D}) chk(addr_bus, mem_addr(code, y));
      end
      test_mode <= 1'h1;
      @(posedge clk);
      {op_byte, op_valid} <= {8'h00, 1'h1};
      repeat (5) @(posedge clk);
      a = addr_bus;
      @(posedge clk);
      chk(addr_bus, a + 16'h1);
      reset <= 1'h1;
      @(posedge clk);
      chk(addr_bus, 16'h0);
      print_verdict();
   end
   initial
   begin
      #1000000 errors++;
      print_verdict();
   end
endmodule // cpu_transfer_test_wait_decode_tb
